// ### rtl/pst_pkg.sv
/*
 * Package for the second-mark pulse and sentence timing block: register map,
 * field layout, reset values, timing constants, types.
 * Assumes a 200 MHz pclk and an APB master with 32-bit data.
 */
package pst_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ = 200;
	localparam int SECOND_MS = 1000;
	localparam int WIDTH_DEF_MS = 100;
	localparam int SYNC_LAT_MIN_MS = 465;
	localparam int SYNC_LAT_MAX_MS = 485;
	localparam int SYNC_LAT_MID_MS = (SYNC_LAT_MIN_MS + SYNC_LAT_MAX_MS) / 2;
	localparam int CYC_PER_MS = CLK_MHZ * 1000;
	localparam int UPD_MAX_HZ = 10;
	localparam int AUG_MAX_HZ = 5;
	localparam int SYNC_RATE_HZ = 1;
	localparam int BAUD_SYNC_MIN = 14400;
	localparam int BAUD_SYNC_MAX = 115200;
	localparam int BAUD_LOW_A = 9600;
	localparam int BAUD_LOW_B = 4800;
	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_WIDTH = 8'h04;
	localparam logic [7:0] OFS_RATE = 8'h08;
	localparam logic [7:0] OFS_BAUD = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_SECONDS = 8'h14;
	// ctrl fields
	localparam int CTRL_POL = 0;
	localparam int CTRL_SYNC = 1;
	localparam int CTRL_AUG = 2;
	localparam int CTRL_ALL = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [3:0] RATE_RESET = 4'h1;
	localparam logic [17:0] BAUD_RESET = 18'h1C200;
	localparam logic [31:0] WIDTH_RESET = 32'h0131_2D00;
	// status fields
	localparam int ST_SYNC_OK = 0;
	localparam int ST_RMC_ONLY = 1;
	localparam int ST_AUG_ON = 2;
	localparam int ST_TX_BUSY = 3;

	typedef struct packed {
		logic pol_low;
		logic [3:0] rate_hz;
		logic [31:0] width_cyc;
	} pst_cfg_type;

	typedef struct packed {
		logic start;
		logic rmc_only;
	} pst_req_type;
endpackage : pst_pkg

// ### rtl/pst_top.sv
/*
 * Second-mark pulse generator with pulse-synced sentence start scheduler,
 * APB register slave and a small serial transmitter stub that frames one
 * start byte per sentence slot.
 * Assumes sentence content comes from elsewhere: tx_byte/tx_more inputs.
 */
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
module pst_top #(
	parameter int SEC_CYC = pst_pkg::SECOND_MS * pst_pkg::CYC_PER_MS,
	parameter int LAT_CYC = pst_pkg::SYNC_LAT_MID_MS * pst_pkg::CYC_PER_MS,
	parameter int CLK_HZ = pst_pkg::CLK_MHZ * 1000000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] tx_byte,
	input wire logic tx_more,
	output logic tx_take,
	output logic second_mark_pulse,
	output logic sentence_serial_out,
	output logic rmc_only
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [3:0] ctrl_reg, ctrl_next;
	logic [31:0] width_reg, width_next;
	logic [3:0] rate_reg, rate_next;
	logic [17:0] baud_reg, baud_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next, pslverr_reg, pslverr_next;
	pst_pkg::pst_cfg_type act_reg, act_next;
	logic [31:0] sec_cnt_reg, sec_cnt_next;
	logic [31:0] sub_cnt_reg, sub_cnt_next;
	logic [31:0] seconds_reg, seconds_next;
	logic mark_reg, mark_next;
	logic sched_reg, sched_next;
	logic [31:0] lat_reg, lat_next;
	logic req_reg, req_next, rmc_reg, rmc_next;
	logic [31:0] bdiv_reg, bdiv_next;
	logic [3:0] bit_reg, bit_next;
	logic [9:0] shf_reg, shf_next;
	logic busy_reg, busy_next, take_reg, take_next;
	logic txo_reg, txo_next;
	logic wr, rd, sync_ok, low_baud, aug_ok, sec_end, slot_end;
	logic [31:0] slot_len, bit_len, slot_new;

	// ************************************************************
	// apb slave, zero wait states
	// ************************************************************
	// read data and error are decoded in setup so they stand through the access cycle
	assign rd = psel && !penable;
	// a write lands only on the access edge that completes the transfer
	assign wr = psel && penable && pwrite && pready_reg;
	always_comb begin
		ctrl_next = ctrl_reg;
		width_next = width_reg;
		rate_next = rate_reg;
		baud_next = baud_reg;
		prdata_next = prdata_reg;
		pready_next = rd;
		pslverr_next = 1'b0;
		if (rd) begin
			case (paddr)
				pst_pkg::OFS_CTRL: prdata_next = {28'h0000000, ctrl_reg};
				pst_pkg::OFS_WIDTH: prdata_next = width_reg;
				pst_pkg::OFS_RATE: prdata_next = {28'h0000000, rate_reg};
				pst_pkg::OFS_BAUD: prdata_next = {14'h0000, baud_reg};
				pst_pkg::OFS_STATUS: prdata_next = {28'h0000000, busy_reg, aug_ok, low_baud, sync_ok};
				pst_pkg::OFS_SECONDS: prdata_next = seconds_reg;
				default: begin
					prdata_next = 32'h00000000;
					pslverr_next = 1'b1; // unmapped address
				end
			endcase
		end
		if (wr) begin
			case (paddr)
				pst_pkg::OFS_CTRL: ctrl_next = pwdata[3:0];
				pst_pkg::OFS_WIDTH: width_next = pwdata;
				pst_pkg::OFS_RATE: begin
					// clamp to the top rate
					if (pwdata[3:0] > 4'(pst_pkg::UPD_MAX_HZ) || pwdata[31:4] != 28'h0000000) begin
						rate_next = 4'(pst_pkg::UPD_MAX_HZ);
					end else if (pwdata[3:0] == 4'h0) begin
						rate_next = 4'h1;
					end else begin
						rate_next = pwdata[3:0];
					end
				end
				pst_pkg::OFS_BAUD: baud_next = pwdata[17:0];
				default: ; // unmapped write is dropped
			endcase
		end
	end

	// ************************************************************
	// feature qualifiers
	// ************************************************************
	assign sync_ok = ctrl_reg[pst_pkg::CTRL_SYNC] && act_reg.rate_hz == 4'(pst_pkg::SYNC_RATE_HZ)
		&& ((baud_reg >= 18'(pst_pkg::BAUD_SYNC_MIN) && baud_reg <= 18'(pst_pkg::BAUD_SYNC_MAX))
		|| low_baud);
	assign low_baud = baud_reg == 18'(pst_pkg::BAUD_LOW_A) || baud_reg == 18'(pst_pkg::BAUD_LOW_B);
	assign aug_ok = ctrl_reg[pst_pkg::CTRL_AUG] && rate_reg <= 4'(pst_pkg::AUG_MAX_HZ);

	// ************************************************************
	// second counter and pulse
	// ************************************************************
	assign sec_end = sec_cnt_reg == 32'(SEC_CYC - 1);
	assign slot_len = 32'(SEC_CYC) / {28'h0000000, act_reg.rate_hz};
	assign slot_end = sub_cnt_reg >= slot_len - 32'h1;
	// width is judged against the slot of the rate about to be latched, not the old one
	assign slot_new = 32'(SEC_CYC) / {28'h0000000, rate_reg};
	always_comb begin
		act_next = act_reg;
		sec_cnt_next = sec_end ? 32'h0 : sec_cnt_reg + 32'h1;
		seconds_next = sec_end ? seconds_reg + 32'h1 : seconds_reg;
		sub_cnt_next = (sec_end || slot_end) ? 32'h0 : sub_cnt_reg + 32'h1;
		if (sec_end) begin
			// latch config only here so no pulse is cut short
			act_next.pol_low = ctrl_reg[pst_pkg::CTRL_POL];
			act_next.rate_hz = rate_reg;
			act_next.width_cyc = (width_reg < slot_new && width_reg != 32'h0) ? width_reg : slot_new >> 1;
		end
		// active while inside the width of the current slot
		mark_next = (sub_cnt_next < act_next.width_cyc) ^ act_next.pol_low;
	end

	// ************************************************************
	// sentence scheduler: fixed latency after the mark's leading edge at the second boundary
	// ************************************************************
	always_comb begin
		sched_next = sched_reg;
		lat_next = lat_reg;
		req_next = 1'b0;
		rmc_next = rmc_reg;
		if (sec_end && sync_ok) begin
			sched_next = 1'b1;
			lat_next = 32'h0;
		end else if (sched_reg) begin
			lat_next = lat_reg + 32'h1;
			if (lat_reg == 32'(LAT_CYC - 1)) begin
				sched_next = 1'b0;
				req_next = 1'b1;
				rmc_next = low_baud;
			end
		end else if (!ctrl_reg[pst_pkg::CTRL_SYNC] && slot_end) begin
			req_next = 1'b1; // free running: once per update slot
			rmc_next = 1'b0;
		end
	end

	// ************************************************************
	// serial transmitter, 8N1, idle high
	// ************************************************************
	assign bit_len = 32'(CLK_HZ) / {14'h0000, (baud_reg == 18'h0 ? 18'h1 : baud_reg)};
	always_comb begin
		bdiv_next = bdiv_reg;
		bit_next = bit_reg;
		shf_next = shf_reg;
		busy_next = busy_reg;
		take_next = 1'b0;
		txo_next = txo_reg;
		if (!busy_reg) begin
			txo_next = 1'b1;
			if (req_reg || (tx_more && take_reg == 1'b0 && bit_reg == 4'hF)) begin
				shf_next = {1'b1, tx_byte, 1'b0};
				busy_next = 1'b1;
				take_next = 1'b1;
				bdiv_next = 32'h0;
				bit_next = 4'h0;
			end else begin
				bit_next = 4'h0;
			end
		end else begin
			txo_next = shf_reg[0];
			if (bdiv_reg >= bit_len - 32'h1) begin
				bdiv_next = 32'h0;
				shf_next = {1'b1, shf_reg[9:1]};
				bit_next = bit_reg + 4'h1;
				if (bit_reg == 4'h9) begin
					busy_next = 1'b0;
					bit_next = tx_more ? 4'hF : 4'h0; // chain bytes of one batch
				end
			end else begin
				bdiv_next = bdiv_reg + 32'h1;
			end
		end
	end

	// ************************************************************
	// state registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= pst_pkg::CTRL_RESET;
			width_reg <= pst_pkg::WIDTH_RESET;
			rate_reg <= pst_pkg::RATE_RESET;
			baud_reg <= pst_pkg::BAUD_RESET;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			act_reg <= '{pol_low: 1'b0, rate_hz: pst_pkg::RATE_RESET, width_cyc: pst_pkg::WIDTH_RESET};
			sec_cnt_reg <= 32'h0;
			sub_cnt_reg <= 32'h0;
			seconds_reg <= 32'h0;
			mark_reg <= 1'b0;
			sched_reg <= 1'b0;
			lat_reg <= 32'h0;
			req_reg <= 1'b0;
			rmc_reg <= 1'b0;
			bdiv_reg <= 32'h0;
			bit_reg <= 4'h0;
			shf_reg <= 10'h3FF;
			busy_reg <= 1'b0;
			take_reg <= 1'b0;
			txo_reg <= 1'b1;
		end else begin
			ctrl_reg <= ctrl_next;
			width_reg <= width_next;
			rate_reg <= rate_next;
			baud_reg <= baud_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
			act_reg <= act_next;
			sec_cnt_reg <= sec_cnt_next;
			sub_cnt_reg <= sub_cnt_next;
			seconds_reg <= seconds_next;
			mark_reg <= mark_next;
			sched_reg <= sched_next;
			lat_reg <= lat_next;
			req_reg <= req_next;
			rmc_reg <= rmc_next;
			bdiv_reg <= bdiv_next;
			bit_reg <= bit_next;
			shf_reg <= shf_next;
			busy_reg <= busy_next;
			take_reg <= take_next;
			txo_reg <= txo_next;
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign second_mark_pulse = mark_reg;
	assign sentence_serial_out = txo_reg;
	assign tx_take = take_reg;
	assign rmc_only = rmc_reg;

	// ************************************************************
	// assertions
	// ************************************************************
	property p_rise_on_boundary;
		@(posedge pclk) disable iff (!presetn)
		(!act_reg.pol_low && $past(act_reg.pol_low) == 1'b0 && $rose(mark_reg))
			|-> $past(sec_end || slot_end || sub_cnt_reg == 32'h0);
	endproperty
	a_rise_on_boundary: assert property (p_rise_on_boundary) else $error("pulse rose off a slot boundary");
	property p_sync_req;
		@(posedge pclk) disable iff (!presetn)
		req_reg && sched_reg == 1'b0 && $past(sched_reg) |-> $past(lat_reg) == 32'(LAT_CYC - 1);
	endproperty
	a_sync_req: assert property (p_sync_req) else $error("synced start at wrong latency");
	property p_rate_max;
		@(posedge pclk) disable iff (!presetn) rate_reg <= 4'(pst_pkg::UPD_MAX_HZ) && rate_reg != 4'h0;
	endproperty
	a_rate_max: assert property (p_rate_max) else $error("update rate out of range");
	property p_aug;
		@(posedge pclk) disable iff (!presetn) rate_reg > 4'(pst_pkg::AUG_MAX_HZ) |-> !aug_ok;
	endproperty
	a_aug: assert property (p_aug) else $error("augmentation on above limit");
	property p_cfg_hold;
		@(posedge pclk) disable iff (!presetn) !$past(sec_end) |-> $stable(act_reg);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed mid second");
	property p_idle_high;
		@(posedge pclk) disable iff (!presetn) $past(!busy_reg, 2) && $past(!busy_reg) |-> txo_reg;
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not idle high");
endmodule : pst_top

// ### sim/pst_host_model.sv
/* host side model: sentence byte source, pulse timer and 8N1 serial receiver.
 * assumes the bench scales the second so one serial bit spans BIT_CYC pclk cycles. */
`timescale 1ns/100ps
module pst_host_model #(
	parameter int BIT_CYC = 20
) (
	input wire logic pclk,
	input wire logic second_mark_pulse,
	input wire logic sentence_serial_out,
	input wire logic tx_take,
	output logic [7:0] tx_byte,
	output logic tx_more,
	output int hi_len,
	output int period,
	output int lat,
	output logic [7:0] rx_byte,
	output logic [7:0] sent_byte
);
	// ************************************************************
	// measurement
	// ************************************************************
	int cnt_per;
	int cnt_hi;
	logic pulse_q;
	logic ser_q;
	logic got;
	logic [7:0] next_byte = 8'h24;
	// one byte per batch, so the stub never chains a second byte after the first
	assign tx_more = 1'b0;
	assign tx_byte = next_byte;
	// counters restart on each raw rising edge of the pulse
	always @(posedge pclk) begin
		pulse_q <= second_mark_pulse;
		ser_q <= sentence_serial_out;
		cnt_per <= cnt_per + 1;
		if (second_mark_pulse && !pulse_q) begin
			period <= cnt_per;
			cnt_per <= 1;
			cnt_hi <= 1;
			got <= 1'b0;
		end else if (second_mark_pulse) begin
			cnt_hi <= cnt_hi + 1;
		end
		if (!second_mark_pulse && pulse_q) hi_len <= cnt_hi;
		// only the first start bit after the mark counts as latency
		if (ser_q && !sentence_serial_out && got === 1'b0) begin
			lat <= cnt_per;
			got <= 1'b1;
		end
		if (tx_take) begin
			sent_byte <= next_byte;
			next_byte <= next_byte + 8'h01;
		end
	end
	// receiver samples mid-bit; misframes at slower baud, which no check relies on
	initial begin
		forever begin
			@(negedge sentence_serial_out);
			repeat (BIT_CYC / 2) @(posedge pclk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge pclk);
				rx_byte[i] = sentence_serial_out;
			end
			repeat (BIT_CYC) @(posedge pclk);
		end
	end
endmodule : pst_host_model

// ### sim/pst_top_bench.sv
/* self-checking bench for pst_top: apb tasks and timing scenarios.
 * assumes a second scaled to 2000 cycles and 20-cycle bits at 115200 baud. */
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module pst_top_bench;
	localparam int SEC = 2000;
	localparam logic [3:0] TR [6] = '{4'h1, 4'h1, 4'h1, 4'h2, 4'h1, 4'h1};
	localparam logic [31:0] TB [6] = '{32'h1C200, 32'h3840, 32'h30D40, 32'h1C200, 32'h2580, 32'h12C0};
	localparam logic [1:0] TS [6] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2, 2'h2};
	localparam logic [1:0] TM [6] = '{2'h3, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2};
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00, tx_byte, rx_byte, sent;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, tx_more, tx_take, pulse, ser, rmc, err;
	int hi_len, period, lat, mismatches = 0, compares = 0, cyc = 0;
	// ************************************************************
	// design and host
	// ************************************************************
	pst_top #(.SEC_CYC(SEC), .LAT_CYC(950), .CLK_HZ(2304000)) pst_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_byte(tx_byte), .tx_more(tx_more), .tx_take(tx_take),
		.second_mark_pulse(pulse), .sentence_serial_out(ser), .rmc_only(rmc));
	pst_host_model #(.BIT_CYC(20)) pst_host_model_inst (.pclk(pclk), .second_mark_pulse(pulse),
		.sentence_serial_out(ser), .tx_take(tx_take), .tx_byte(tx_byte), .tx_more(tx_more), .hi_len(hi_len),
		.period(period), .lat(lat), .rx_byte(rx_byte), .sent_byte(sent));
	// 200 MHz clock and a hang guard well past the planned 19 seconds
	always #2.5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	// ************************************************************
	// tasks
	// ************************************************************
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'b0, a, 32'h0);
		`CHK(n, e, q)
	endtask : rd
	// config only lands at a boundary, so wait for the next mark
	task automatic next_sec();
		@(posedge pulse);
		repeat (4) @(posedge pclk);
	endtask : next_sec
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(pst_pkg::OFS_CTRL, 32'h0, "ctrl");
		rd(pst_pkg::OFS_WIDTH, 32'h0131_2D00, "width");
		rd(pst_pkg::OFS_RATE, 32'h1, "rate");
		rd(pst_pkg::OFS_BAUD, 32'h1C200, "baud");
		rd(8'h18, 32'h0, "unmapped");
		`CHK("unmapped err", 1'b1, err)
		$display("test reset done");
		@(posedge pulse);
		apb(1'b1, pst_pkg::OFS_WIDTH, 32'hC8);
		@(negedge pulse);
		repeat (2) @(posedge pclk);
		`CHK("width in flight", 1000, hi_len)
		@(negedge pulse);
		repeat (2) @(posedge pclk);
		`CHK("width", 200, hi_len)
		`CHK("period", SEC, period)
		$display("test pulse done");
		apb(1'b1, pst_pkg::OFS_CTRL, 32'h2);
		next_sec();
		next_sec();
		repeat (1200) @(posedge pclk);
		`CHK("sync latency", 1'b1, lat >= 930 && lat <= 970)
		`CHK("serial byte", sent, rx_byte)
		`CHK("rmc full", 1'b0, rmc)
		$display("test sync done");
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, pst_pkg::OFS_RATE, {28'h0, TR[i]});
			apb(1'b1, pst_pkg::OFS_BAUD, TB[i]);
			next_sec();
			apb(1'b0, pst_pkg::OFS_STATUS, 32'h0);
			`CHK("status sync", TS[i], q[1:0] & TM[i])
		end
		// low baud with sync on: the next synced batch must be the minimum sentence alone
		repeat (3 * SEC) @(posedge pclk);
		`CHK("rmc only", 1'b1, rmc)
		apb(1'b1, pst_pkg::OFS_BAUD, 32'h1C200);
		apb(1'b1, pst_pkg::OFS_RATE, 32'hC);
		rd(pst_pkg::OFS_RATE, 32'hA, "rate clamp");
		apb(1'b1, pst_pkg::OFS_RATE, 32'h0);
		rd(pst_pkg::OFS_RATE, 32'h1, "rate zero");
		$display("test baud done");
		apb(1'b1, pst_pkg::OFS_CTRL, 32'h4);
		apb(1'b1, pst_pkg::OFS_RATE, 32'h5);
		next_sec();
		apb(1'b0, pst_pkg::OFS_STATUS, 32'h0);
		`CHK("aug at 5", 1'b1, q[2])
		apb(1'b1, pst_pkg::OFS_RATE, 32'h6);
		next_sec();
		apb(1'b0, pst_pkg::OFS_STATUS, 32'h0);
		`CHK("aug at 6", 1'b0, q[2])
		apb(1'b1, pst_pkg::OFS_WIDTH, 32'h32);
		apb(1'b1, pst_pkg::OFS_RATE, 32'hA);
		repeat (2 * SEC) @(posedge pclk);
		`CHK("fast period", SEC / 10, period)
		`CHK("fast width", 50, hi_len)
		apb(1'b1, pst_pkg::OFS_WIDTH, 32'hC8);
		apb(1'b1, pst_pkg::OFS_RATE, 32'h1);
		apb(1'b1, pst_pkg::OFS_CTRL, 32'h1);
		repeat (3 * SEC) @(posedge pclk);
		`CHK("low polarity gap", SEC - 200, hi_len)
		$display("test config done");
		tally_and_finish();
	end
endmodule : pst_top_bench
